// ==== verilog/acbi_top.sv ====
// Sequencer and bus interface of an integrating converter
`timescale 1ns/1ps
`default_nettype none
`include "acbi_regs.svh"

// Overview of operation
// [RQ1] Selector high: top bit shows overrange
// [RQ2] Selector low: top bit shows polarity
// [RQ3] Selector acts only in enabled high-byte read
// [RQ4] Continuous mode ignores both selectors
// [RQ5] Continuous input high runs conversions back to back
// [RQ6] Continuous result lost 443.5 clocks after busy
// [RQ7] Continuous reads step through three bytes
// [RQ8] Sequence: high/polarity, low, high/overrange
// [RQ9] Read strobe rising edge advances byte counter
// [RQ10] Demand mode: enabled convert strobe starts conversion
// [RQ11] Demand mode bytes readable in any order
// [RQ12] Demand result valid until before next busy
// [RQ13] Busy rises at deintegrate, falls at end
// [RQ14] Busy high exactly 836 internal clocks
// [RQ15] Busy driven in both modes
// [RQ16] Demand busy falls 1155 clocks after strobe
// [RQ17] 125 clocks recovery after busy falls
// [RQ18] Strobe ignored 1100 clocks, later one remembered
// [RQ19] Only a falling strobe edge starts conversion
// [RQ20] Internal clock is oscillator over four
// [RQ21] Signal integrate lasts 256 internal clocks
// [RQ22] Host may hold selects in continuous mode
// [RQ23] Host may tie read strobe low in demand
// [RQ24] Host drives selectors from low address bits
// [RQ25] Chip selects ANDed to enable strobes
// [RQ26] Byte selector picks high or low byte
// [RQ27] All result bits latched together at busy fall
module acbi_top (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_clock_input_pin,
  input wire logic i_cs,
  input wire logic i_ce_n,
  input wire logic i_rd_n,
  input wire logic i_wr_n,
  input wire logic i_cont,
  input wire logic i_lh,
  input wire logic i_flag_bit_select,
  input wire acbi_pkg::acbi_data_t i_conv_data,
  input wire logic i_conv_pos,
  input wire logic i_conv_ovr,
  output logic o_bus_top_bit,
  output acbi_pkg::acbi_low7_t o_bus_lower_bits,
  output logic o_bus_oe,
  output logic o_busy,
  output logic o_integrate,
  output logic o_data_valid
);
  import acbi_pkg::*;

  // Cycle positions derived from the timing counts
  localparam acbi_pos_t POS_LAST = 11'(`ACBI_CONV_CLKS - 1);
  localparam acbi_pos_t POS_START = 11'(`ACBI_RECOVER_CLKS);
  localparam acbi_pos_t POS_REC_LAST = 11'(`ACBI_RECOVER_CLKS - 1);
  localparam acbi_pos_t POS_BUSY =
    11'(`ACBI_CONV_CLKS - `ACBI_BUSY_CLKS);
  localparam acbi_pos_t POS_INT_END =
    11'(`ACBI_RECOVER_CLKS + `ACBI_INT_CLKS);
  localparam acbi_pos_t POS_WR_OPEN =
    11'(`ACBI_RECOVER_CLKS + `ACBI_WR_IGNORE_CLKS);
  localparam acbi_pos_t POS_LOSS = 11'(`ACBI_HOLD_CLKS);
  localparam logic [1:0] OSC_LAST = 2'(`ACBI_OSC_DIV - 1);

  // Synchronised pins and their previous values
  acbi_pins_t pins_raw; // Raw pin vector
  acbi_pins_t pins; // Filtered pin vector
  acbi_pins_t pins_prev_q; // One cycle old filtered pins
  logic [2:0] warm_q; // Cycles since reset, stops at the settle count

  // Sequencer state
  acbi_state_t state_q; // Present state
  acbi_state_t state_d; // Next state
  acbi_pos_t pos_q; // Internal clock position in the cycle
  acbi_pos_t pos_d; // Next position
  logic [1:0] osc_q; // Oscillator edges within an internal clock
  logic pending_q; // Remembered convert strobe
  logic pending_d; // Next remembered strobe
  logic busy_d; // Next busy
  logic int_d; // Next integrate flag

  // Result latch and byte counter
  acbi_data_t res_q; // Latched magnitude
  logic pos_bit_q; // Latched polarity
  logic ovr_bit_q; // Latched overrange
  acbi_idx_t idx_q; // Continuous byte counter

  // Decoded strobes
  wire warm; // Synchronisers hold real pin levels
  wire en; // Chip enabled
  wire osc_rise; // Oscillator rising edge
  wire tick; // One internal clock completes
  wire wr_fall; // Enabled convert strobe falling edge
  wire rd_rise; // Enabled read strobe rising edge
  wire rd_sel; // Enabled read active
  wire wr_open; // Convert strobe may be taken
  wire wr_acc; // Convert strobe taken
  wire start_now; // A conversion begins this cycle
  wire at_end; // Last internal clock of a conversion ends
  wire loss_now; // Continuous result expires this cycle
  wire mode_cont; // Continuous mode level

  // Read path towards the output stage
  acbi_rd_if rd ();

  // Pin vector gathered for the synchroniser
  assign pins_raw[`ACBI_PIN_OSC] = i_clock_input_pin;
  assign pins_raw[`ACBI_PIN_CS] = i_cs;
  assign pins_raw[`ACBI_PIN_CE_N] = i_ce_n;
  assign pins_raw[`ACBI_PIN_RD_N] = i_rd_n;
  assign pins_raw[`ACBI_PIN_WR_N] = i_wr_n;
  assign pins_raw[`ACBI_PIN_CONT] = i_cont;
  assign pins_raw[`ACBI_PIN_LH] = i_lh;
  assign pins_raw[`ACBI_PIN_FBS] = i_flag_bit_select;

  // All pins come from outside the clock domain
  acbi_sync u_sync (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_pins(pins_raw),
    .o_pins(pins)
  );

  // Previous pin levels for edge detection
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pins_prev_q <= 8'hff;
    end else begin
      pins_prev_q <= pins;
    end
  end

  // Settle counter; the stages reset low while idle strobes sit high,
  // so edges are masked until the real pin levels have come through
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      warm_q <= 3'h0;
    end else if (!warm) begin
      warm_q <= warm_q + 3'h1;
    end
  end
  assign warm = (warm_q == 3'(`ACBI_SYNC_SETTLE));

  // [RQ25] Active-high and active-low selects combined by AND
  assign en = warm & pins[`ACBI_PIN_CS] & ~pins[`ACBI_PIN_CE_N];
  assign mode_cont = pins[`ACBI_PIN_CONT];

  // [RQ20] Internal clock is every fourth oscillator edge
  assign osc_rise = warm & pins[`ACBI_PIN_OSC] &
                    ~pins_prev_q[`ACBI_PIN_OSC];
  assign tick = osc_rise & (osc_q == OSC_LAST);

  // [RQ19] Only a falling edge of the enabled strobe counts
  assign wr_fall = en & ~pins[`ACBI_PIN_WR_N] &
                   pins_prev_q[`ACBI_PIN_WR_N];
  // [RQ9] Rising read edge while enabled
  assign rd_rise = en & pins[`ACBI_PIN_RD_N] &
                   ~pins_prev_q[`ACBI_PIN_RD_N];
  assign rd_sel = en & ~pins[`ACBI_PIN_RD_N];

  // [RQ18] Strobe ignored during the first part of a conversion
  assign wr_open = (state_q != ACBI_ST_CONVERT) | (pos_q >= POS_WR_OPEN);
  // [RQ10] Demand mode takes the strobe only when selected
  assign wr_acc = wr_fall & ~mode_cont & wr_open;

  // [RQ5] Continuous mode starts without a strobe
  // [RQ17] Start only after the recovery clocks are done
  assign start_now = tick & (
    ((state_q == ACBI_ST_RECOVER) & (pos_q == POS_REC_LAST) &
     (mode_cont | pending_q | wr_acc)) |
    ((state_q == ACBI_ST_IDLE) & (mode_cont | pending_q | wr_acc)));

  // [RQ13] Busy falls at the end of the conversion cycle
  assign at_end = tick & (state_q == ACBI_ST_CONVERT) &
                  (pos_q == POS_LAST);

  // [RQ6] Half a clock before busy would rise the result is lost
  // [RQ12] Demand data also ends half a clock before busy rises
  assign loss_now = osc_rise & (osc_q == `ACBI_HALF_PHASE) &
                    (state_q == ACBI_ST_CONVERT) & (pos_q == POS_LOSS);

  // Oscillator edge counter, divides by four
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      osc_q <= 2'h0;
    end else if (osc_rise) begin
      osc_q <= osc_q + 2'h1;
    end
  end

  // Next state, position and phase outputs
  always_comb begin
    state_d = state_q;
    pos_d = pos_q;
    busy_d = o_busy;
    int_d = o_integrate;
    if (tick) begin
      unique case (state_q)
        ACBI_ST_CONVERT: begin
          if (pos_q == POS_LAST) begin
            // [RQ13] End of cycle, busy falls, recovery begins
            state_d = ACBI_ST_RECOVER;
            pos_d = 11'h000;
            busy_d = 1'b0;
          end else begin
            pos_d = pos_q + 11'h001;
          end
          // [RQ14] Busy rises so it spans exactly 836 clocks
          if (pos_q == POS_BUSY - 11'h001) begin
            busy_d = 1'b1;
          end
          // [RQ21] Integrate phase ends after 256 clocks
          if (pos_q == POS_INT_END - 11'h001) begin
            int_d = 1'b0;
          end
        end
        ACBI_ST_RECOVER: begin
          if (pos_q != POS_REC_LAST) begin
            pos_d = pos_q + 11'h001;
          end else if (!start_now) begin
            state_d = ACBI_ST_IDLE;
            pos_d = POS_START;
          end
        end
        ACBI_ST_IDLE: begin
          pos_d = POS_START;
        end
        default: begin
          state_d = ACBI_ST_IDLE;
          pos_d = POS_START;
        end
      endcase
      // [RQ16] Start at the recovery end or from idle, busy falls 1155 clocks on
      if (start_now) begin
        state_d = ACBI_ST_CONVERT;
        pos_d = POS_START;
        int_d = 1'b1;
      end
    end
  end

  // [RQ18] Later strobe remembered; the clear at a start wins over a new one
  assign pending_d = start_now ? 1'b0 : (pending_q | wr_acc);

  // Sequencer registers
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q <= ACBI_ST_IDLE;
      pos_q <= POS_START;
      pending_q <= 1'b0;
      o_busy <= 1'b0;
      o_integrate <= 1'b0;
    end else begin
      state_q <= state_d;
      pos_q <= pos_d;
      pending_q <= pending_d;
      // [RQ15] Busy is driven in both modes
      o_busy <= busy_d;
      o_integrate <= int_d;
    end
  end

  // [RQ27] Whole result captured at once when busy falls
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      res_q <= 15'h0000;
      pos_bit_q <= 1'b0;
      ovr_bit_q <= 1'b0;
      o_data_valid <= 1'b0;
    end else if (at_end) begin
      res_q <= i_conv_data;
      pos_bit_q <= i_conv_pos;
      ovr_bit_q <= i_conv_ovr;
      o_data_valid <= 1'b1;
    end else if (loss_now) begin
      // [RQ6] Result latch cleared, result no longer available
      res_q <= 15'h0000;
      pos_bit_q <= 1'b0;
      ovr_bit_q <= 1'b0;
      o_data_valid <= 1'b0;
    end
  end

  // [RQ7] Continuous byte counter, restarts with each new result
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      idx_q <= `ACBI_SEQ_HIGH_POL;
    end else if (at_end | loss_now) begin
      idx_q <= `ACBI_SEQ_HIGH_POL;
    end else if (rd_rise & mode_cont) begin
      // [RQ9] Each finished read steps to the next byte
      if (idx_q == `ACBI_SEQ_HIGH_OVR) begin
        idx_q <= `ACBI_SEQ_HIGH_POL;
      end else begin
        idx_q <= idx_q + 2'h1;
      end
    end
  end

  // [RQ11] Demand mode reads are plain selections of the latch
  assign rd.data = res_q;
  assign rd.pos = pos_bit_q;
  assign rd.ovr = ovr_bit_q;
  assign rd.cont = mode_cont;
  assign rd.lh = pins[`ACBI_PIN_LH];
  assign rd.fbs = pins[`ACBI_PIN_FBS];
  assign rd.rd_sel = rd_sel;
  assign rd.idx = idx_q;

  // Registered byte output stage
  acbi_byte_out u_out (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .rd(rd.mux),
    .o_bus_top_bit(o_bus_top_bit),
    .o_bus_lower_bits(o_bus_lower_bits),
    .o_bus_oe(o_bus_oe)
  );
endmodule

`default_nettype wire

// ==== inc/acbi_regs.svh ====
// Timing counts and field positions for the converter bus interface
`ifndef ACBI_REGS_SVH
`define ACBI_REGS_SVH

// Oscillator edges per internal conversion clock
`define ACBI_OSC_DIV 4
// Internal clocks per complete conversion cycle
`define ACBI_CONV_CLKS 1280
// Internal clocks that busy stays high
`define ACBI_BUSY_CLKS 836
// Internal clocks of the signal-integrate phase
`define ACBI_INT_CLKS 256
// Internal clocks of recovery after busy falls
`define ACBI_RECOVER_CLKS 125
// Internal clocks the convert strobe is ignored after a start
`define ACBI_WR_IGNORE_CLKS 1100
// Whole internal clocks of result validity in continuous mode
`define ACBI_HOLD_CLKS 443
// System clocks after reset until the pin synchronisers hold real levels
`define ACBI_SYNC_SETTLE 5
// Oscillator phase that marks half an internal clock
`define ACBI_HALF_PHASE 2'h1
// Field positions within the synchronised pin vector
`define ACBI_PIN_OSC 0
`define ACBI_PIN_CS 1
`define ACBI_PIN_CE_N 2
`define ACBI_PIN_RD_N 3
`define ACBI_PIN_WR_N 4
`define ACBI_PIN_CONT 5
`define ACBI_PIN_LH 6
`define ACBI_PIN_FBS 7
// Byte counter values of the continuous sequence
`define ACBI_SEQ_HIGH_POL 2'h0
`define ACBI_SEQ_LOW 2'h1
`define ACBI_SEQ_HIGH_OVR 2'h2

`endif

// ==== inc/acbi_pkg.sv ====
// Types shared by the converter bus interface modules
package acbi_pkg;

  // Fifteen magnitude bits of a result
  typedef logic [14:0] acbi_data_t;
  // Seven lower data lines of the bus
  typedef logic [6:0] acbi_low7_t;
  // Synchronised pin vector
  typedef logic [7:0] acbi_pins_t;
  // Position within the conversion cycle
  typedef logic [10:0] acbi_pos_t;
  // Continuous-mode byte counter
  typedef logic [1:0] acbi_idx_t;

  // Sequencer states, Gray along convert, recover, idle
  typedef enum logic [1:0] {
    ACBI_ST_CONVERT = 2'h0,
    ACBI_ST_RECOVER = 2'h1,
    ACBI_ST_IDLE = 2'h3
  } acbi_state_t;

endpackage

// ==== inc/acbi_rd_if.sv ====
// Read path signals between the sequencer and the byte output stage
`timescale 1ns/1ps
`default_nettype none

interface acbi_rd_if;
  import acbi_pkg::*;

  acbi_data_t data; // Latched magnitude
  logic pos; // Latched polarity, high for positive
  logic ovr; // Latched overrange
  logic cont; // Continuous mode
  logic lh; // Byte selector, high picks the low byte
  logic fbs; // Flag bit selector
  logic rd_sel; // Enabled read active
  acbi_idx_t idx; // Continuous byte counter

  modport prod (
    output data, pos, ovr, cont, lh, fbs, rd_sel, idx
  );
  modport mux (
    input data, pos, ovr, cont, lh, fbs, rd_sel, idx
  );
endinterface

`default_nettype wire

// ==== verilog/acbi_sync.sv ====
// Three-stage synchroniser with agreement filter for the pin inputs
`timescale 1ns/1ps
`default_nettype none

module acbi_sync (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire acbi_pkg::acbi_pins_t i_pins,
  output acbi_pkg::acbi_pins_t o_pins
);
  import acbi_pkg::*;

  // One synchroniser per pin
  for (genvar g = 0; g < 8; g++) begin : g_bit
    logic s1_q; // First stage, read by the second only
    logic s2_q; // Second stage
    logic s3_q; // Third stage
    logic st_q; // Accepted level
    // Shift chain, level accepted once stages two and three agree
    always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        s1_q <= 1'b0;
        s2_q <= 1'b0;
        s3_q <= 1'b0;
        st_q <= 1'b0;
      end else begin
        s1_q <= i_pins[g];
        s2_q <= s1_q;
        s3_q <= s2_q;
        if (s2_q == s3_q) begin
          st_q <= s3_q;
        end
      end
    end
    assign o_pins[g] = st_q;
  end
endmodule

`default_nettype wire

// ==== verilog/acbi_byte_out.sv ====
// Registered data bus driver with byte and flag selection
`timescale 1ns/1ps
`default_nettype none
`include "acbi_regs.svh"

module acbi_byte_out (
  input wire logic i_clk,
  input wire logic i_rst_n,
  acbi_rd_if.mux rd,
  output logic o_bus_top_bit,
  output acbi_pkg::acbi_low7_t o_bus_lower_bits,
  output logic o_bus_oe
);
  import acbi_pkg::*;

  logic top_d; // Next top line
  acbi_low7_t low_d; // Next lower lines
  logic flag_dem; // Demand-mode flag choice
  logic top_cont; // Continuous-mode top line
  acbi_low7_t low_cont; // Continuous-mode lower lines
  logic top_dem; // Demand-mode top line
  acbi_low7_t low_dem; // Demand-mode lower lines

  // [RQ1] Selector high gives overrange, [RQ2] low gives polarity
  assign flag_dem = rd.fbs ? rd.ovr : rd.pos;
  // [RQ26] Low selector gives high byte, high gives low byte
  assign top_dem = rd.lh ? rd.data[7] : flag_dem;
  assign low_dem = rd.lh ? rd.data[6:0] : rd.data[14:8];
  // [RQ8] Fixed sequence: high with polarity, low, high with overrange
  assign top_cont = (rd.idx == `ACBI_SEQ_LOW) ? rd.data[7] :
                    (rd.idx == `ACBI_SEQ_HIGH_OVR) ? rd.ovr : rd.pos;
  assign low_cont = (rd.idx == `ACBI_SEQ_LOW) ? rd.data[6:0] :
                    rd.data[14:8];
  // [RQ4] Continuous mode ignores both selectors
  assign top_d = rd.cont ? top_cont : top_dem;
  assign low_d = rd.cont ? low_cont : low_dem;

  // Output register; lines drive only during an enabled read
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_bus_top_bit <= 1'b0;
      o_bus_lower_bits <= 7'h00;
      o_bus_oe <= 1'b0;
    end else begin
      o_bus_top_bit <= top_d;
      o_bus_lower_bits <= low_d;
      // [RQ3] Selector acts only inside an enabled read
      o_bus_oe <= rd.rd_sel;
    end
  end
endmodule

`default_nettype wire

// ==== sim/acbi_top_chk.sv ====
// Port-level timing checks for the converter bus interface
`timescale 1ns/1ps
`default_nettype none

module acbi_top_chk (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_clock_input_pin,
  input wire logic i_cs,
  input wire logic i_ce_n,
  input wire logic i_rd_n,
  input wire logic i_cont,
  input wire logic o_bus_oe,
  input wire logic o_busy,
  input wire logic o_integrate,
  input wire logic o_data_valid
);
  // Oscillator edges per phase; one edge of slack for pin skew, two for the hold check
  localparam int BusyEdges = 836 * 4;
  localparam int IntEdges = 256 * 4;
  localparam int HoldEdges = 1774;
  logic osc_q; // Oscillator pin one cycle back
  logic cont_all_q; // Continuous mode held since busy high
  int busy_cnt_q; // Oscillator edges while busy
  int int_cnt_q; // Oscillator edges while integrating
  int dv_cnt_q; // Oscillator edges since busy fell
  wire osc_rise = i_clock_input_pin & ~osc_q; // Raw oscillator rise
  wire en_rd = i_cs & ~i_ce_n & ~i_rd_n; // Enabled read
  wire cont_all_d = o_busy ? i_cont : (cont_all_q & i_cont);

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  // Edge counters for phase lengths
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      osc_q <= 1'h0;
      cont_all_q <= 1'h0;
      busy_cnt_q <= 0;
      int_cnt_q <= 0;
      dv_cnt_q <= 0;
    end else begin
      osc_q <= i_clock_input_pin;
      cont_all_q <= cont_all_d;
      busy_cnt_q <= o_busy ? busy_cnt_q + int'(osc_rise) : 0;
      int_cnt_q <= o_integrate ? int_cnt_q + int'(osc_rise) : 0;
      dv_cnt_q <= o_busy ? 0 : dv_cnt_q + int'(osc_rise);
    end
  end

  property p_busy_len;
    $fell(o_busy) |-> busy_cnt_q >= BusyEdges - 1
      && busy_cnt_q <= BusyEdges + 1;
  endproperty
  a_busy_len: assert property (p_busy_len)
    else $error("Busy high period has the wrong length");
  property p_int_len;
    $fell(o_integrate) |-> int_cnt_q >= IntEdges - 1
      && int_cnt_q <= IntEdges + 1;
  endproperty
  a_int_len: assert property (p_int_len)
    else $error("Integrate phase has the wrong length");
  property p_dv_busy;
    $fell(o_busy) |-> o_data_valid;
  endproperty
  a_dv_busy: assert property (p_dv_busy)
    else $error("Result not valid at busy fall");
  property p_busy_excl;
    o_busy |-> !o_data_valid;
  endproperty
  a_busy_excl: assert property (p_busy_excl)
    else $error("Result still flagged valid while busy");
  property p_int_excl;
    o_integrate |-> !o_busy;
  endproperty
  a_int_excl: assert property (p_int_excl)
    else $error("Busy high during signal integrate");
  property p_hold;
    cont_all_q && o_data_valid |-> dv_cnt_q <= HoldEdges + 2;
  endproperty
  a_hold: assert property (p_hold)
    else $error("Continuous result held too long");
  property p_oe_on;
    en_rd [*8] |-> o_bus_oe;
  endproperty
  a_oe_on: assert property (p_oe_on)
    else $error("Bus not driven during enabled read");
  property p_oe_off;
    !en_rd [*8] |-> !o_bus_oe;
  endproperty
  a_oe_off: assert property (p_oe_off)
    else $error("Bus driven without enabled read");
endmodule

bind acbi_top acbi_top_chk i_acbi_top_chk (
  .i_clk(i_clk),
  .i_rst_n(i_rst_n),
  .i_clock_input_pin(i_clock_input_pin),
  .i_cs(i_cs),
  .i_ce_n(i_ce_n),
  .i_rd_n(i_rd_n),
  .i_cont(i_cont),
  .o_bus_oe(o_bus_oe),
  .o_busy(o_busy),
  .o_integrate(o_integrate),
  .o_data_valid(o_data_valid)
);

`default_nettype wire

// ==== sim/acbi_host.sv ====
// Host model driving the converter control pins
`timescale 1ns/1ps
`default_nettype none

module acbi_host (
  input wire logic i_clk,
  input wire logic i_bus_top_bit,
  input wire acbi_pkg::acbi_low7_t i_bus_lower_bits,
  input wire logic i_bus_oe,
  output var logic o_osc,
  output var logic o_cs,
  output var logic o_ce_n,
  output var logic o_rd_n,
  output var logic o_wr_n,
  output var logic o_cont,
  output var logic o_lh,
  output var logic o_fbs
);
  import acbi_pkg::*;
  int osc_n = 0; // Cycle within oscillator period

  // Idle pins at time zero
  initial begin
    o_osc = 1'h0;
    o_cs = 1'h0;
    o_ce_n = 1'h1;
    o_rd_n = 1'h1;
    o_wr_n = 1'h1;
    o_cont = 1'h0;
    o_lh = 1'h0;
    o_fbs = 1'h0;
  end

  // Free-running external oscillator, ten clocks a period
  always @(negedge i_clk) begin
    osc_n = (osc_n + 1) % 10;
    o_osc <= (osc_n < 5);
  end

  task automatic set_pins(input logic cs, ce_n, cont, lh, fbs);
    @(negedge i_clk);
    o_cs = cs;
    o_ce_n = ce_n;
    o_cont = cont;
    o_lh = lh;
    o_fbs = fbs;
  endtask

  // Convert strobe level
  task automatic wr_set(input logic v);
    @(negedge i_clk);
    o_wr_n = v;
  endtask

  // Demand host may hold the read strobe low
  task automatic rd_set(input logic v);
    @(negedge i_clk);
    o_rd_n = v;
  endtask

  // Read strobe back high after each byte
  task automatic read(output logic [7:0] b, output logic oe);
    @(negedge i_clk);
    o_rd_n = 1'h0;
    repeat (8) @(negedge i_clk);
    b = {i_bus_top_bit, i_bus_lower_bits};
    oe = i_bus_oe;
    o_rd_n = 1'h1;
    repeat (8) @(negedge i_clk);
  endtask
endmodule

`default_nettype wire

// ==== sim/tb_acbi_top.sv ====
// Self-checking bench for the converter bus interface
`timescale 1ns/1ps
`default_nettype none

module tb_acbi_top;
  import acbi_pkg::*;
  logic clk = 1'h0; // 200 MHz clock
  logic rst_n = 1'h0; // Reset, active low
  logic osc, cs, ce_n, rd_n, wr_n, cont, lh, fbs; // Host pins
  acbi_data_t cdata = 15'h0000; // Converter magnitude
  logic cpos = 1'h0; // Converter polarity
  logic covr = 1'h0; // Converter overrange
  logic top, oe, busy, integ, dv; // Device outputs
  acbi_low7_t low7; // Lower data lines
  int miscompares = 0;
  int comparisons = 0;

  always #2.5 clk = ~clk;

  acbi_top i_acbi_top (.i_clk(clk), .i_rst_n(rst_n),
    .i_clock_input_pin(osc), .i_cs(cs), .i_ce_n(ce_n), .i_rd_n(rd_n),
    .i_wr_n(wr_n), .i_cont(cont), .i_lh(lh), .i_flag_bit_select(fbs),
    .i_conv_data(cdata), .i_conv_pos(cpos), .i_conv_ovr(covr),
    .o_bus_top_bit(top), .o_bus_lower_bits(low7), .o_bus_oe(oe),
    .o_busy(busy), .o_integrate(integ), .o_data_valid(dv));

  acbi_host i_acbi_host (.i_clk(clk), .i_bus_top_bit(top),
    .i_bus_lower_bits(low7), .i_bus_oe(oe), .o_osc(osc), .o_cs(cs),
    .o_ce_n(ce_n), .o_rd_n(rd_n), .o_wr_n(wr_n), .o_cont(cont),
    .o_lh(lh), .o_fbs(fbs));

  // Compare and count
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Wait for a busy level under a bound
  task automatic wait_busy(input logic v);
    int n;
    n = 0;
    while (busy !== v && n < 60000) begin
      @(negedge clk);
      n++;
    end
    chk({7'h00, busy}, {7'h00, v});
  endtask

  task automatic t_enable();
    logic [7:0] b;
    logic e;
    // One select missing each pass: first the high one, then the low one
    for (int k = 0; k < 2; k++) begin
      i_acbi_host.set_pins(k[0], k[0], 1'h0, 1'h0, 1'h0);
      i_acbi_host.wr_set(1'h0);
      i_acbi_host.read(b, e);
      i_acbi_host.wr_set(1'h1);
      repeat (200) @(negedge clk);
      chk({7'h00, e}, 8'h00);
      chk({7'h00, integ}, 8'h00);
    end
  endtask

  // Demand conversion, early and held strobes, reads
  task automatic t_demand();
    longint t0;
    int n;
    logic seen;
    logic [7:0] b;
    logic e;
    logic [1:0] sel [4];
    sel = '{2'h3, 2'h1, 2'h0, 2'h2};
    seen = 1'h0;
    cdata = 15'h5a3c;
    cpos = 1'h1;
    covr = 1'h0;
    i_acbi_host.set_pins(1'h1, 1'h0, 1'h0, 1'h0, 1'h0);
    i_acbi_host.wr_set(1'h0);
    t0 = $time;
    repeat (10) @(negedge clk);
    i_acbi_host.wr_set(1'h1);
    repeat (400) @(negedge clk);
    i_acbi_host.wr_set(1'h0);
    wait_busy(1'h1);
    wait_busy(1'h0);
    n = int'(($time - t0) / 5);
    chk({7'h00, n >= 46160 && n <= 46320}, 8'h01);
    chk({7'h00, dv}, 8'h01);
    repeat (5200) begin
      @(negedge clk);
      seen = seen | integ;
    end
    chk({7'h00, seen}, 8'h00);
    i_acbi_host.wr_set(1'h1);
    for (int k = 0; k < 4; k++) begin
      i_acbi_host.set_pins(1'h1, 1'h0, 1'h0, sel[k][1], sel[k][0]);
      i_acbi_host.read(b, e);
      chk({7'h00, e}, 8'h01);
      if (sel[k][1]) begin
        chk(b, cdata[7:0]);
      end else begin
        chk(b, {sel[k][0] ? covr : cpos, cdata[14:8]});
      end
    end
    // Read strobe held low; only the byte selector moves
    i_acbi_host.rd_set(1'h0);
    for (int k = 0; k < 2; k++) begin
      i_acbi_host.set_pins(1'h1, 1'h0, 1'h0, k[0], 1'h1);
      repeat (8) @(negedge clk);
      chk({top, low7}, k[0] ? cdata[7:0] : {covr, cdata[14:8]});
    end
    i_acbi_host.rd_set(1'h1);
  endtask

  // Continuous run and fixed byte sequence
  task automatic t_cont();
    logic [7:0] b;
    logic e;
    logic [7:0] exp [3];
    cdata = 15'h2b96;
    cpos = 1'h0;
    covr = 1'h1;
    exp = '{{1'h0, 7'h2b}, 8'h96, {1'h1, 7'h2b}};
    i_acbi_host.set_pins(1'h1, 1'h0, 1'h1, 1'h1, 1'h1);
    wait_busy(1'h1);
    wait_busy(1'h0);
    cdata = 15'h0000;
    cpos = 1'h1;
    covr = 1'h0;
    // All three bytes well inside the hold time
    for (int k = 0; k < 3; k++) begin
      i_acbi_host.read(b, e);
      chk(b, exp[k]);
    end
    i_acbi_host.set_pins(1'h1, 1'h0, 1'h0, 1'h0, 1'h0);
  endtask

  // Counts and verdict
  task automatic print_verdict();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (20) @(negedge clk);
    rst_n = 1'h1;
    repeat (10) @(negedge clk);
    t_enable();
    t_demand();
    t_cont();
    print_verdict();
  end

  // Watchdog against a hang
  initial begin
    repeat (104000) @(posedge clk);
    miscompares++;
    print_verdict();
  end
endmodule

`default_nettype wire
